//--- inc/swp_regs.svh
// Register indices, field positions, reset values and timing counts
// for the sync window pulse timing block.
// Assumes a single 40 MHz core clock and an 8-bit indexed host port.
`ifndef SWP_REGS_SVH
`define SWP_REGS_SVH

// ==========================================================
// Pair numbers; index byte is {pair, high-byte flag}
`define SWP_PAIR_CLAMP_START 4'h0
`define SWP_PAIR_CLAMP_STOP 4'h1
`define SWP_PAIR_ZERO_START 4'h2
`define SWP_PAIR_ZERO_STOP 4'h3
`define SWP_PAIR_FIELD_START 4'h4
`define SWP_PAIR_FIELD_STOP 4'h5
`define SWP_PAIR_FILTER_CLOSE 4'h6
`define SWP_PAIR_FILTER_OPEN 4'h7
`define SWP_PAIR_LINE_LENGTH 4'h8
`define SWP_PAIR_COUNT 9

// ==========================================================
// Field positions inside the index byte and the high byte
`define SWP_IDX_HI_BIT 0
`define SWP_IDX_PAIR_LSB 1
`define SWP_IDX_PAIR_MSB 4
`define SWP_IDX_SPARE_LSB 5
`define SWP_HI_DATA_MSB 3
`define SWP_HI_MASK 8'h0f

// ==========================================================
// Reset values
`define SWP_VALUE_RESET 12'h000
`define SWP_BYTE_RESET 8'h00
`define SWP_INDEX_RESET 8'h00

// ==========================================================
// Timing
`define SWP_CLEAR_PIPE 3
`define SWP_PHASE_DLY_NS 500
`define SWP_CLK_MHZ 40

`endif

//--- inc/swp_pkg.sv
// Types shared by the sync window pulse timing block.
// Assumes the constants header is compiled alongside.
package swp_pkg;

   // ==========================================================
   // Count and window carriers
   typedef logic [11:0] swp_count_t;
   typedef logic [3:0] swp_pair_t;

   typedef struct packed {
      swp_count_t start;
      swp_count_t stop;
   } swp_win_s;

   // ==========================================================
   // Host port sequencer
   typedef enum logic [2:0] {
      PORT_IDLE = 3'b001,
      PORT_WRITE = 3'b010,
      PORT_READ = 3'b100
   } swp_port_e;

endpackage : swp_pkg

//--- rtl/swp_window_cmp.sv
// One start/stop window on the horizontal count.
// Assumes line_length only moves on pixEn and both values are 12-bit.
`timescale 1ns/1ps

module swp_window_cmp
   import swp_pkg::*;
(
   input wire logic core_clk, // 40 MHz core clock
   input wire logic rst_n, // Synchronous reset, low
   input wire logic pixEn, // Pixel clock enable
   input swp_count_t line_length, // Horizontal count
   input swp_win_s win, // Start and stop counts
   output logic level // Window level
);

   // ==========================================================
   // Compare decode
   wire logic equalVals;
   wire logic hitStart;
   wire logic hitStop;
   logic levelReg;

   assign equalVals = (win.start == win.stop);
   assign hitStart = (line_length == win.start);
   assign hitStop = (line_length == win.stop);
   assign level = levelReg;

   // Equal values pin the level high; start wins a tie with stop
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         levelReg <= 1'b0;
      end else if (equalVals) begin
         levelReg <= 1'b1;
      end else if (pixEn && hitStart) begin
         levelReg <= 1'b1;
      end else if (pixEn && hitStop) begin
         levelReg <= 1'b0;
      end
   end

endmodule : swp_window_cmp

//--- rtl/swp_timing_top.sv
// Horizontal timing window generator for a video sync separator.
// Assumes all inputs synchronous to core_clk; pixEn is the pixel rate.
//
// How it works
// - High byte bits 7..4 ignored, read zero
// - Low byte held; high write commits value
// - Zero high at start, low at stop
// - Zero start equals stop: zero held high
// - Value n means count of n+1 clocks
// - Counter clear lags sync edge three clocks
// - Field polarity follows start/stop order
// - Field start equals stop: field held high
// - Field changes only at vsync falling edge or when start equals stop
// - Gate closes at start, opens at stop
// - Gate start equals stop: stays closed
// - Fixed phase-limit delay after sync edge
// - Line length holds pixels minus one
// - Clamp high at start, low at stop
// - Index select picks index or register
`timescale 1ns/1ps
`include "swp_regs.svh"

module swp_timing_top
   import swp_pkg::*;
#(
   parameter int PAIRS = `SWP_PAIR_COUNT // Split registers
)(
   input wire logic core_clk, // 40 MHz core clock
   input wire logic rst_n, // Synchronous reset, low
   input wire logic pixEn, // Pixel clock enable pulse
   input wire logic compositeSyncN, // Filtered composite sync, low
   input wire logic vsyncN, // Vertical sync, low
   input wire logic indexSelect, // 0 index, 1 data register
   input wire logic rdN, // Host read strobe, low
   input wire logic wrN, // Host write strobe, low
   input wire logic [7:0] dataIn, // Host data in
   output logic [7:0] dataOut, // Host data out
   output logic dataOeN, // Data drive enable, low
   output logic clampOut, // Clamp window
   output logic zeroOut, // Zero window
   output logic fieldOut, // Field parity
   output logic syncFilterClosed, // Noise gate closed
   output logic phaseLimitPulse, // Phase-limit delay done
   output swp_count_t hCountOut // Horizontal count
);

   // ==========================================================
   // Derived timing
   localparam int PHASE_DLY_CYC =
      (`SWP_PHASE_DLY_NS * `SWP_CLK_MHZ + 999) / 1000;
   localparam int DLY_W = $clog2(PHASE_DLY_CYC + 1);
   localparam logic [DLY_W-1:0] PHASE_DLY_LOAD = DLY_W'(PHASE_DLY_CYC);
   localparam logic [DLY_W-1:0] DLY_ONE = DLY_W'(1);
   localparam logic [DLY_W-1:0] DLY_ZERO = '0;

   // ==========================================================
   // Index decode, shared by the write and read paths
   function automatic logic idxMapped(input logic [7:0] idx);
      idxMapped = (idx[7:`SWP_IDX_SPARE_LSB] == 3'h0) &&
         (idx[`SWP_IDX_PAIR_MSB:`SWP_IDX_PAIR_LSB] <= `SWP_PAIR_LINE_LENGTH);
   endfunction : idxMapped

   function automatic swp_pair_t idxPair(input logic [7:0] idx);
      idxPair = idx[`SWP_IDX_PAIR_MSB:`SWP_IDX_PAIR_LSB];
   endfunction : idxPair

   // ==========================================================
   // Storage
   swp_port_e portState_reg;
   swp_port_e portState_next;
   logic [7:0] index_reg;
   logic [7:0] wrData_reg;
   logic wrSel_reg;
   logic [7:0] readData_reg;
   swp_count_t value_reg [PAIRS];
   logic [7:0] lowHold_reg [PAIRS];
   swp_count_t line_length_reg;
   logic syncPrev_reg;
   logic vsyncPrev_reg;
   logic edgePend_reg;
   logic [`SWP_CLEAR_PIPE-2:0] clearPipe_reg; // Counter flop is the last stage
   logic field_reg;
   logic [DLY_W-1:0] phaseDly_reg;
   logic phasePulse_reg;

   // ==========================================================
   // Host port sequencer
   wire logic writeDone;
   wire logic readActive;
   wire logic wrMapped;
   wire swp_pair_t wrPair;
   wire logic wrHigh;
   wire logic rdMapped;
   wire swp_pair_t rdPair;
   wire logic rdHigh;
   logic [7:0] readMux;

   // Commit happens on the rising edge of the write strobe
   assign writeDone = (portState_reg == PORT_WRITE) && wrN;
   assign readActive = (portState_reg == PORT_READ) && !rdN;
   assign dataOeN = !readActive;
   assign dataOut = readData_reg;

   // Next state; a strobe held low keeps its state
   always_comb begin
      portState_next = portState_reg;
      case (portState_reg)
         PORT_IDLE: begin
            if (!wrN) begin
               portState_next = PORT_WRITE;
            end else if (!rdN) begin
               portState_next = PORT_READ;
            end
         end
         PORT_WRITE: begin
            if (wrN) begin
               portState_next = PORT_IDLE;
            end
         end
         PORT_READ: begin
            if (rdN) begin
               portState_next = PORT_IDLE;
            end
         end
         default: begin
            portState_next = PORT_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         portState_reg <= PORT_IDLE;
      end else begin
         portState_reg <= portState_next;
      end
   end

   // Data and select tracked while the write strobe is low
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wrData_reg <= `SWP_BYTE_RESET;
         wrSel_reg <= 1'b0;
      end else if (!wrN) begin
         wrData_reg <= dataIn;
         wrSel_reg <= indexSelect;
      end
   end

   // ==========================================================
   // Register writes
   assign wrMapped = idxMapped(index_reg);
   assign wrPair = idxPair(index_reg);
   assign wrHigh = index_reg[`SWP_IDX_HI_BIT];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         index_reg <= `SWP_INDEX_RESET;
      end else if (writeDone && !wrSel_reg) begin
         index_reg <= wrData_reg;
      end
   end

   // One slice per split register pair
   for (genvar g = 0; g < PAIRS; g++) begin : gSplit
      wire logic hit;
      assign hit = writeDone && wrSel_reg && wrMapped && (wrPair == swp_pair_t'(g));

      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            lowHold_reg[g] <= `SWP_BYTE_RESET;
         end else if (hit && !wrHigh) begin
            lowHold_reg[g] <= wrData_reg;
         end
      end

      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            value_reg[g] <= `SWP_VALUE_RESET;
         end else if (hit && wrHigh) begin
            value_reg[g] <= {wrData_reg[`SWP_HI_DATA_MSB:0], lowHold_reg[g]};
         end
      end
   end

   // ==========================================================
   // Register reads
   assign rdMapped = idxMapped(index_reg);
   assign rdPair = idxPair(index_reg);
   assign rdHigh = index_reg[`SWP_IDX_HI_BIT];

   always_comb begin
      readMux = `SWP_BYTE_RESET;
      if (!indexSelect) begin
         readMux = index_reg;
      end else if (rdMapped && rdHigh) begin
         readMux = {4'h0, value_reg[rdPair][11:8]} & `SWP_HI_MASK;
      end else if (rdMapped) begin
         readMux = value_reg[rdPair][7:0];
      end
   end

   // Read data flopped; unmapped indices read zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         readData_reg <= `SWP_BYTE_RESET;
      end else begin
         readData_reg <= readMux;
      end
   end

   // ==========================================================
   // Window wiring
   swp_win_s win [4];
   logic [3:0] winLevel;
   swp_count_t lineLength;

   assign lineLength = value_reg[`SWP_PAIR_LINE_LENGTH];
   assign win[0] = {value_reg[`SWP_PAIR_CLAMP_START], value_reg[`SWP_PAIR_CLAMP_STOP]};
   assign win[1] = {value_reg[`SWP_PAIR_ZERO_START], value_reg[`SWP_PAIR_ZERO_STOP]};
   assign win[2] = {value_reg[`SWP_PAIR_FIELD_START], value_reg[`SWP_PAIR_FIELD_STOP]};
   assign win[3] = {value_reg[`SWP_PAIR_FILTER_CLOSE], value_reg[`SWP_PAIR_FILTER_OPEN]};

   // clamp, zero, field gate, noise gate
   for (genvar w = 0; w < 4; w++) begin : gWin
      swp_window_cmp uWin (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .pixEn(pixEn),
         .line_length(line_length_reg),
         .win(win[w]),
         .level(winLevel[w])
      );
   end

   // zero pinned high, gate stays closed, both in the comparator
   assign clampOut = winLevel[0];
   assign zeroOut = winLevel[1];
   assign syncFilterClosed = winLevel[3];
   assign hCountOut = line_length_reg;

   // ==========================================================
   // Sync edge detection through the noise gate
   wire logic syncFall;
   wire logic syncTaken;
   wire logic clearNow;

   assign syncFall = syncPrev_reg && !compositeSyncN;
   assign syncTaken = syncFall && !syncFilterClosed;
   assign clearNow = pixEn && clearPipe_reg[`SWP_CLEAR_PIPE-2];

   // Edge history
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         syncPrev_reg <= 1'b1;
         vsyncPrev_reg <= 1'b1;
      end else begin
         syncPrev_reg <= compositeSyncN;
         vsyncPrev_reg <= vsyncN;
      end
   end

   // Edge held until the next pixel clock picks it up
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         edgePend_reg <= 1'b0;
      end else if (syncTaken) begin
         edgePend_reg <= 1'b1;
      end else if (pixEn) begin
         edgePend_reg <= 1'b0;
      end
   end

   // three pixel clocks of clear delay
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         clearPipe_reg <= '0;
      end else if (pixEn) begin
         clearPipe_reg <= {clearPipe_reg[`SWP_CLEAR_PIPE-3:0], edgePend_reg | syncTaken};
      end
   end

   // ==========================================================
   // Horizontal counter
   // restart at edge or line end
   // line length is pixels minus one
   // count n is the (n+1)th clock
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         line_length_reg <= `SWP_VALUE_RESET;
      end else if (clearNow) begin
         line_length_reg <= `SWP_VALUE_RESET;
      end else if (pixEn && (line_length_reg == lineLength)) begin
         line_length_reg <= `SWP_VALUE_RESET;
      end else if (pixEn) begin
         line_length_reg <= line_length_reg + 12'h001;
      end
   end

   // ==========================================================
   // Field parity
   wire logic vsyncFall;
   wire logic fieldEqual;
   wire logic fieldStartAbove;

   assign vsyncFall = vsyncPrev_reg && !vsyncN;
   assign fieldEqual = (win[2].start == win[2].stop);
   assign fieldStartAbove = (win[2].start > win[2].stop);
   assign fieldOut = field_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         field_reg <= 1'b1;
      end else if (fieldEqual) begin
         field_reg <= 1'b1;
      end else if (vsyncFall) begin
         field_reg <= fieldStartAbove ? winLevel[2] : !winLevel[2];
      end
   end

   // ==========================================================
   // Phase-limit delay
   // Counted in core clocks so it stays fixed whatever the pixel rate
   assign phaseLimitPulse = phasePulse_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         phaseDly_reg <= DLY_ZERO;
      end else if (syncTaken) begin
         phaseDly_reg <= PHASE_DLY_LOAD;
      end else if (phaseDly_reg != DLY_ZERO) begin
         phaseDly_reg <= phaseDly_reg - DLY_ONE;
      end
   end

   // One-cycle pulse as the delay runs out
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         phasePulse_reg <= 1'b0;
      end else begin
         phasePulse_reg <= !syncTaken && (phaseDly_reg == DLY_ONE);
      end
   end

endmodule : swp_timing_top

//--- sim/swp_timing_top_properties.sv
// Port-level assertions for the sync window pulse timing block.
// Assumes binding onto swp_timing_top; one clock, synchronous reset.
`timescale 1ns/1ps

module swp_timing_top_properties
   import swp_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Reset, low
   input wire logic pixEn, // Pixel enable
   input wire logic compositeSyncN, // Composite sync, low
   input wire logic vsyncN, // Vertical sync, low
   input wire logic rdN, // Read strobe, low
   input wire logic wrN, // Write strobe, low
   input wire logic dataOeN, // Data drive, low
   input wire logic fieldOut, // Field parity
   input wire logic syncFilterClosed, // Gate closed
   input wire logic phaseLimitPulse, // Phase pulse
   input wire swp_count_t hCountOut // Horizontal count
);
   // ==========
   // Shared clock and reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Sync edge seen while the gate is open
   sequence s_edge;
      $fell(compositeSyncN) && !syncFilterClosed;
   endsequence

   // ==========
   // Counter
   property p_hold;
      !pixEn |=> $stable(hCountOut);
   endproperty
   a_hold: assert property (p_hold)
      else $error("count moved without pixel enable");

   property p_step;
      pixEn |=> (hCountOut == $past(hCountOut) + 12'h001) || (hCountOut == 12'h000);
   endproperty
   a_step: assert property (p_step)
      else $error("count skipped a value");

   property p_clear;
      s_edge |-> ##[1:10] hCountOut == 12'h000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("count not cleared after sync edge");

   // ==========
   // Phase limit and field
   property p_phase;
      s_edge |-> ##[19:21] phaseLimitPulse;
   endproperty
   a_phase: assert property (p_phase)
      else $error("phase pulse missing after sync edge");

   property p_pulse;
      phaseLimitPulse |=> !phaseLimitPulse;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("phase pulse wider than one cycle");

   // Reset forces the level, so the cycle after it is excluded
   property p_field;
      $changed(fieldOut) && $past(rst_n) |-> $past(vsyncN, 2) && !$past(vsyncN);
   endproperty
   a_field: assert property (p_field)
      else $error("field moved away from vsync fall");

   // ==========
   // Host port
   property p_rdHi;
      rdN |-> dataOeN;
   endproperty
   a_rdHi: assert property (p_rdHi)
      else $error("data driven without read strobe");

   property p_wrNo;
      !wrN |-> dataOeN;
   endproperty
   a_wrNo: assert property (p_wrNo)
      else $error("data driven during write");

   property p_rdAns;
      $fell(rdN) && wrN |=> !dataOeN;
   endproperty
   a_rdAns: assert property (p_rdAns)
      else $error("read not answered");

   c_edge: cover property (s_edge);
   c_phase: cover property (phaseLimitPulse);
   c_read: cover property (!dataOeN);
endmodule : swp_timing_top_properties

bind swp_timing_top swp_timing_top_properties i_swp_timing_top_properties (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .pixEn(pixEn),
   .compositeSyncN(compositeSyncN),
   .vsyncN(vsyncN),
   .rdN(rdN),
   .wrN(wrN),
   .dataOeN(dataOeN),
   .fieldOut(fieldOut),
   .syncFilterClosed(syncFilterClosed),
   .phaseLimitPulse(phaseLimitPulse),
   .hCountOut(hCountOut)
);

//--- sim/swp_host_model.sv
// Host processor and pixel rate source facing the timing block.
// Assumes strobes are sampled on rising core_clk edges.
`timescale 1ns/1ps

module swp_host_model (
   input wire logic core_clk, // Core clock
   input wire logic [7:0] dataOut, // Read data
   input wire logic dataOeN, // Read drive, low
   output logic pixEn, // Pixel enable
   output logic indexSelect, // Index or data
   output logic rdN, // Read strobe, low
   output logic wrN, // Write strobe, low
   output logic [7:0] dataIn // Write data
);
   // ==========
   // Idle port, pixel pulse every second clock
   initial begin
      indexSelect = 1'b0;
      rdN = 1'b1;
      wrN = 1'b1;
      dataIn = 8'h00;
      pixEn = 1'b0;
      forever begin
         @(negedge core_clk);
         pixEn = ~pixEn;
      end
   end

   // ==========
   // Port cycles; data inverted after release so stale bytes never match
   // index or data
   task automatic hostCycle(input logic sel, input logic rd, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge core_clk);
      indexSelect = sel;
      dataIn = d;
      rdN = !rd;
      wrN = rd;
      @(negedge core_clk);
      @(negedge core_clk);
      q = dataOeN ? 8'hxx : dataOut;
      rdN = 1'b1;
      wrN = 1'b1;
      dataIn = ~d;
      @(negedge core_clk);
   endtask : hostCycle

   // low then high; junk upper nibble
   task automatic setReg(input logic [3:0] pair, input logic [11:0] v);
      logic [7:0] q;
      hostCycle(1'b0, 1'b0, {3'h0, pair, 1'b0}, q);
      hostCycle(1'b1, 1'b0, v[7:0], q);
      hostCycle(1'b0, 1'b0, {3'h0, pair, 1'b1}, q);
      hostCycle(1'b1, 1'b0, {4'ha, v[11:8]}, q);
   endtask : setReg

   task automatic getByte(input logic [7:0] idx, output logic [7:0] q);
      hostCycle(1'b0, 1'b0, idx, q);
      hostCycle(1'b1, 1'b1, 8'h00, q);
   endtask : getByte
endmodule : swp_host_model

//--- sim/swp_timing_top_tb.sv
// Self-checking bench for the sync window pulse timing block.
// Assumes the host model drives the port and the pixel enable.
`timescale 1ns/1ps
`include "swp_regs.svh"

module swp_timing_top_tb;
   import swp_pkg::*;

   logic core_clk, rst_n, compositeSyncN, vsyncN, pixEn;
   logic indexSelect, rdN, wrN, dataOeN, clampOut, zeroOut;
   logic fieldOut, syncFilterClosed, phaseLimitPulse;
   logic [7:0] dataIn, dataOut, q;
   swp_count_t hCountOut;
   int miscompares = 0;
   int checks = 0;

   // ==========
   // Design and host
   swp_timing_top i_swp_timing_top (.core_clk(core_clk), .rst_n(rst_n), .pixEn(pixEn),
      .compositeSyncN(compositeSyncN), .vsyncN(vsyncN), .indexSelect(indexSelect),
      .rdN(rdN), .wrN(wrN), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
      .clampOut(clampOut), .zeroOut(zeroOut), .fieldOut(fieldOut),
      .syncFilterClosed(syncFilterClosed), .phaseLimitPulse(phaseLimitPulse),
      .hCountOut(hCountOut));
   swp_host_model i_swp_host_model (.core_clk(core_clk), .dataOut(dataOut),
      .dataOeN(dataOeN), .pixEn(pixEn), .indexSelect(indexSelect), .rdN(rdN),
      .wrN(wrN), .dataIn(dataIn));

   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ==========
   // Helpers
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Bounded wait for a count value
   task automatic waitCnt(input swp_count_t n);
      int i;
      i = 0;
      do begin
         @(negedge core_clk);
         i++;
      end while (hCountOut !== n && i < 200);
      if (i >= 200) chk("count wait", n, hCountOut);
   endtask : waitCnt

   task automatic stop_test();
      if (miscompares == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   // ==========
   // Scenarios
   task automatic testReset();
      chk("zero", 12'h001, 12'(zeroOut));
      chk("clamp", 12'h001, 12'(clampOut));
      chk("gate", 12'h001, 12'(syncFilterClosed));
      chk("field", 12'h001, 12'(fieldOut));
   endtask : testReset

   // Low byte alone held; high nibble masked; unmapped index ignored
   task automatic testPort();
      i_swp_host_model.hostCycle(1'b0, 1'b0, 8'h00, q);
      i_swp_host_model.hostCycle(1'b1, 1'b0, 8'h5a, q);
      i_swp_host_model.getByte(8'h00, q);
      chk("low held", 12'h000, 12'(q));
      i_swp_host_model.hostCycle(1'b0, 1'b0, 8'h01, q);
      i_swp_host_model.hostCycle(1'b1, 1'b0, 8'hf3, q);
      i_swp_host_model.getByte(8'h00, q);
      chk("low", 12'h05a, 12'(q));
      i_swp_host_model.getByte(8'h01, q);
      chk("high", 12'h003, 12'(q));
      i_swp_host_model.hostCycle(1'b0, 1'b0, 8'h20, q);
      i_swp_host_model.hostCycle(1'b1, 1'b0, 8'h77, q);
      i_swp_host_model.getByte(8'h20, q);
      chk("unmapped", 12'h000, 12'(q));
   endtask : testPort

   task automatic testWindows();
      // line length and gate first; gate kept open
      i_swp_host_model.setReg(`SWP_PAIR_LINE_LENGTH, 12'd11);
      i_swp_host_model.setReg(`SWP_PAIR_FILTER_CLOSE, 12'hff0);
      i_swp_host_model.setReg(`SWP_PAIR_FILTER_OPEN, 12'h001);
      // zero nested inside clamp; clamp after sync, scaled to the short line
      i_swp_host_model.setReg(`SWP_PAIR_ZERO_START, 12'd3);
      i_swp_host_model.setReg(`SWP_PAIR_ZERO_STOP, 12'd5);
      i_swp_host_model.setReg(`SWP_PAIR_CLAMP_START, 12'd2);
      i_swp_host_model.setReg(`SWP_PAIR_CLAMP_STOP, 12'd6);
      waitCnt(12'd11);
      while (hCountOut === 12'd11) @(negedge core_clk);
      chk("wrap", 12'h000, hCountOut);
      waitCnt(12'd3);
      chk("clamp on", 12'h001, 12'(clampOut));
      chk("zero early", 12'h000, 12'(zeroOut));
      waitCnt(12'd4);
      chk("zero on", 12'h001, 12'(zeroOut));
      waitCnt(12'd6);
      chk("zero off", 12'h000, 12'(zeroOut));
      waitCnt(12'd7);
      chk("clamp off", 12'h000, 12'(clampOut));
      i_swp_host_model.setReg(`SWP_PAIR_ZERO_START, 12'd7);
      i_swp_host_model.setReg(`SWP_PAIR_ZERO_STOP, 12'd7);
      waitCnt(12'd2);
      chk("zero equal", 12'h001, 12'(zeroOut));
      waitCnt(12'd9);
      chk("zero equal", 12'h001, 12'(zeroOut));
   endtask : testWindows

   task automatic testSync();
      // gate closes before half the line
      i_swp_host_model.setReg(`SWP_PAIR_FILTER_CLOSE, 12'd4);
      i_swp_host_model.setReg(`SWP_PAIR_FILTER_OPEN, 12'd8);
      waitCnt(12'd2);
      @(posedge core_clk iff pixEn);
      @(negedge core_clk);
      compositeSyncN = 1'b0;
      repeat (2) @(posedge core_clk iff pixEn);
      @(negedge core_clk);
      chk("count pre clear", 12'd5, hCountOut);
      @(posedge core_clk iff pixEn);
      @(negedge core_clk);
      chk("count cleared", 12'h000, hCountOut);
      compositeSyncN = 1'b1;
      waitCnt(12'd6);
      chk("gate closed", 12'h001, 12'(syncFilterClosed));
      compositeSyncN = 1'b0;
      repeat (3) @(posedge core_clk iff pixEn);
      @(negedge core_clk);
      chk("edge ignored", 12'd9, hCountOut);
      chk("gate open", 12'h000, 12'(syncFilterClosed));
      compositeSyncN = 1'b1;
   endtask : testSync

   // Field parity from the window level at the vsync fall
   task automatic fieldCase(input swp_count_t st, input swp_count_t sp,
         input swp_count_t at, input logic was, input logic exp);
      i_swp_host_model.setReg(`SWP_PAIR_FIELD_START, st);
      i_swp_host_model.setReg(`SWP_PAIR_FIELD_STOP, sp);
      waitCnt(12'd0);
      waitCnt(at);
      chk("field hold", 12'(was), 12'(fieldOut));
      vsyncN = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("field", 12'(exp), 12'(fieldOut));
      vsyncN = 1'b1;
   endtask : fieldCase

   // ==========
   // Main sequence and watchdog
   initial begin
      rst_n = 1'b0;
      compositeSyncN = 1'b1;
      vsyncN = 1'b1;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      testReset();
      testPort();
      testWindows();
      testSync();
      // window at a quarter and three quarters of the 12-pixel line, then start 8 above stop 3
      fieldCase(12'd3, 12'd9, 12'd5, 1'b1, 1'b0);
      fieldCase(12'd3, 12'd9, 12'd10, 1'b0, 1'b1);
      fieldCase(12'd8, 12'd3, 12'd5, 1'b1, 1'b0);
      fieldCase(12'd8, 12'd3, 12'd10, 1'b0, 1'b1);
      stop_test();
   end

   // Whole run needs under a thousand clocks
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      stop_test();
   end
endmodule : swp_timing_top_tb
